/* File: pkg/bct_defs.vh */
`ifndef BCT_DEFS_VH
`define BCT_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------
`define BCT_OFF_EXT_MODE_A 12'h000
`define BCT_OFF_EXT_MODE_B 12'h004
`define BCT_OFF_AUX_CTRL 12'h008
`define BCT_OFF_PRELOAD_LO 12'h00c
`define BCT_OFF_PRELOAD_HI 12'h010
`define BCT_OFF_INT_STATUS 12'h014
`define BCT_OFF_INT_MASK 12'h018
`define BCT_OFF_CMD_A 12'h01c
`define BCT_OFF_CMD_B 12'h020
`define BCT_OFF_START 12'h024
`define BCT_OFF_STOP 12'h028
`define BCT_OFF_CLK_SEL_A 12'h02c
`define BCT_OFF_CLK_SEL_B 12'h030
`define BCT_OFF_COUNT 12'h034

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BCT_EXT_RATE_BIT 0
`define BCT_AUX_MODE_BIT 6
`define BCT_AUX_SRC_LO 4
`define BCT_READY_BIT 3
`define BCT_CMD_LO 4
`define BCT_SEL_TX_LO 8

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define BCT_CMD_TIMEOUT_ON 4'ha
`define BCT_CMD_TIMEOUT_OFF 4'hc
`define BCT_SRC_EXT_PIN 2'h0
`define BCT_SRC_REF 2'h1
`define BCT_SRC_REF_DIV16 2'h2
`define BCT_SRC_TX_A 2'h3
`define BCT_SEL_CT 6'h1f
`define BCT_SEL_EXT 6'h20
`define BCT_NUM_STD_RATES 28
`define BCT_NUM_EXT_RATES 3
`define BCT_PRESCALE_LAST 4'hf
`define BCT_PRELOAD_RST 8'h00
`define BCT_AUX_RST 3'h0
`define BCT_SEL_RST 6'h00
`define BCT_ROLLOVER 16'hffff

`endif

/* File: design/bct_rate_gen.v */
`include "bct_defs.vh"

// Fixed rate generator: one divider per tap, each emitting a one-cycle
// strobe at sixteen times its baud rate, counted in reference ticks.
module bct_rate_gen #(
	parameter NUM_TAPS = 31,
	parameter CW = 13
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire ref_tick_in,
	input wire ext_rates_in,
	output wire [NUM_TAPS-1:0] tap_out
);

	// ------------------------------------------------------------
	// Divisor table, in reference ticks per 16x strobe.
	// ------------------------------------------------------------
	function [CW-1:0] tap_div;
		input integer idx;
		begin
			case (idx)
				0: tap_div = 13'h1200;
				1: tap_div = 13'h0c00;
				2: tap_div = 13'h0900;
				3: tap_div = 13'h082f;
				4: tap_div = 13'h06b1;
				5: tap_div = 13'h0600;
				6: tap_div = 13'h0480;
				7: tap_div = 13'h0400;
				8: tap_div = 13'h0300;
				9: tap_div = 13'h0200;
				10: tap_div = 13'h0180;
				11: tap_div = 13'h0100;
				12: tap_div = 13'h00e6;
				13: tap_div = 13'h00db;
				14: tap_div = 13'h00c0;
				15: tap_div = 13'h0080;
				16: tap_div = 13'h0073;
				17: tap_div = 13'h0060;
				18: tap_div = 13'h004d;
				19: tap_div = 13'h0040;
				20: tap_div = 13'h0030;
				21: tap_div = 13'h0020;
				22: tap_div = 13'h0018;
				23: tap_div = 13'h0012;
				24: tap_div = 13'h0010;
				25: tap_div = 13'h000c;
				26: tap_div = 13'h0008;
				27: tap_div = 13'h0006;
				28: tap_div = 13'h0004;
				29: tap_div = 13'h0002;
				default: tap_div = 13'h0001;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// One divider per tap; extended taps stay silent unless enabled.
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_TAPS; i = i + 1)
		begin : g_tap
			reg [CW-1:0] cnt_q;
			reg tick_q;
			wire tap_en = (i < `BCT_NUM_STD_RATES) || ext_rates_in;
			// Counting reference ticks keeps every rate proportional.
			always @(posedge clk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					cnt_q <= {CW{1'b0}};
					tick_q <= 1'b0;
				end
				else if (ref_tick_in)
				begin
					if (cnt_q == tap_div(i) - 1'b1)
					begin
						cnt_q <= {CW{1'b0}};
						tick_q <= tap_en;
					end
					else
					begin
						cnt_q <= cnt_q + 1'b1;
						tick_q <= 1'b0;
					end
				end
				else
				begin
					tick_q <= 1'b0;
				end
			end
			assign tap_out[i] = tick_q;
		end
	endgenerate

endmodule

/* File: design/bct_clk_sel.v */
`include "bct_defs.vh"

// One clock selector: picks a rate tap, the counter/timer or an
// external timing input and re-times the chosen strobe.
module bct_clk_sel #(
	parameter NUM_TAPS = 31
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire [5:0] sel_in,
	input wire [NUM_TAPS-1:0] taps_in,
	input wire ct_tick_in,
	input wire ext_tick_in,
	output reg tick_out
);

	reg pick;

	// ------------------------------------------------------------
	// Source choice; unassigned codes give no clock at all.
	// ------------------------------------------------------------
	always @*
	begin
		pick = 1'b0;
		if (sel_in == `BCT_SEL_CT)
			pick = ct_tick_in;
		else if (sel_in == `BCT_SEL_EXT)
			pick = ext_tick_in;
		else if (sel_in < NUM_TAPS)
			pick = taps_in[sel_in[4:0]];
	end

	// Registered so the strobe is glitch free for the channel logic.
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			tick_out <= 1'b0;
		else
			tick_out <= pick;
	end

endmodule

/* File: design/bct_top.v */
// The APB interface to the registers and the register addresses were decided locally.
`include "bct_defs.vh"

module bct_top #(
	parameter NUM_TAPS = 31,
	parameter AW = 12
) (
	input wire CLK_IN,
	input wire NRST_IN,
	input wire REF_CLOCK_IN,
	input wire EXT_CT_IN,
	input wire EXT_CLK_A_IN,
	input wire EXT_CLK_B_IN,
	input wire RX_CHAR_A_IN,
	input wire RX_CHAR_B_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [AW-1:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	output wire [31:0] PRDATA_OUT,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	output wire IRQ_OUT,
	output wire CT_OUT_OUT,
	output wire RX_CLK_A_OUT,
	output wire TX_CLK_A_OUT,
	output wire RX_CLK_B_OUT,
	output wire TX_CLK_B_OUT
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	reg rst_meta_q;
	reg rst_n_q;
	reg [3:0] pin_meta_q;
	reg [3:0] pin_sync_q;
	reg [3:0] pin_prev_q;
	reg [3:0] pre_q;
	reg [2:0] ext_a_q;
	reg [2:0] ext_b_q;
	reg [2:0] aux_q;
	reg [7:0] pre_lo_q;
	reg [7:0] pre_hi_q;
	reg ready_q;
	reg mask_q;
	reg [5:0] sel_q [0:3];
	reg to_a_q;
	reg to_b_q;
	reg [15:0] count_q;
	reg ct_out_q;
	reg ct_prev_q;
	reg running_q;
	reg [31:0] rdata_q;
	reg [31:0] rd_mux;
	reg ct_tick;
	wire [3:0] pin_rise;
	wire ref_tick;
	wire ref16_tick;
	wire [NUM_TAPS-1:0] taps;
	wire [3:0] sel_tick;
	wire [15:0] preload;
	wire ct_fall;
	wire setup_rd;
	wire acc;
	wire wr;
	wire rd;
	wire [3:0] idx;
	wire start_cmd;
	wire stop_cmd;
	wire [3:0] cmd;
	wire to_on_a;
	wire to_on_b;
	wire to_any;
	wire to_enter;
	wire char_in;
	wire expire;
	wire timer_mode;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Gives a register number, or 4'hf for an unmapped address.
	function [3:0] reg_index;
		input [AW-1:0] a;
		begin
			if (a == `BCT_OFF_EXT_MODE_A)
				reg_index = 4'h0;
			else if (a == `BCT_OFF_EXT_MODE_B)
				reg_index = 4'h1;
			else if (a == `BCT_OFF_AUX_CTRL)
				reg_index = 4'h2;
			else if (a == `BCT_OFF_PRELOAD_LO)
				reg_index = 4'h3;
			else if (a == `BCT_OFF_PRELOAD_HI)
				reg_index = 4'h4;
			else if (a == `BCT_OFF_INT_STATUS)
				reg_index = 4'h5;
			else if (a == `BCT_OFF_INT_MASK)
				reg_index = 4'h6;
			else if (a == `BCT_OFF_CMD_A)
				reg_index = 4'h7;
			else if (a == `BCT_OFF_CMD_B)
				reg_index = 4'h8;
			else if (a == `BCT_OFF_START)
				reg_index = 4'h9;
			else if (a == `BCT_OFF_STOP)
				reg_index = 4'ha;
			else if (a == `BCT_OFF_CLK_SEL_A)
				reg_index = 4'hb;
			else if (a == `BCT_OFF_CLK_SEL_B)
				reg_index = 4'hc;
			else if (a == `BCT_OFF_COUNT)
				reg_index = 4'hd;
			else
				reg_index = 4'hf;
		end
	endfunction

	// ------------------------------------------------------------
	// Reset release and pin synchronisers
	// ------------------------------------------------------------
	// Reset asserts at once but leaves through two flops.
	always @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// The reference clock pin is sampled, not used as a clock, so the
	// reference must stay well below half of CLK_IN.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			pin_prev_q <= 4'h0;
		end
		else
		begin
			pin_meta_q <= {EXT_CLK_B_IN, EXT_CLK_A_IN, EXT_CT_IN,
				REF_CLOCK_IN};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pin_rise = pin_sync_q & ~pin_prev_q;
	assign ref_tick = pin_rise[0];

	// Divide-by-16 prescaler for the slow counter clock source.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
			pre_q <= 4'h0;
		else if (ref_tick)
			pre_q <= pre_q + 1'b1;
	end

	assign ref16_tick = ref_tick && (pre_q == `BCT_PRESCALE_LAST);

	// ------------------------------------------------------------
	// Rate generator and clock selectors
	// ------------------------------------------------------------
	bct_rate_gen #(
		.NUM_TAPS(NUM_TAPS),
		.CW(13)
	) u_rate_gen (
		.clk_in(CLK_IN),
		.rst_n_in(rst_n_q),
		.ref_tick_in(ref_tick),
		.ext_rates_in(ext_a_q[`BCT_EXT_RATE_BIT]),
		.tap_out(taps)
	);

	// Order: receiver A, transmitter A, receiver B, transmitter B.
	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1)
		begin : g_sel
			bct_clk_sel #(
				.NUM_TAPS(NUM_TAPS)
			) u_sel (
				.clk_in(CLK_IN),
				.rst_n_in(rst_n_q),
				.sel_in(sel_q[s]),
				.taps_in(taps),
				.ct_tick_in(ct_fall),
				.ext_tick_in(pin_rise[2 + s / 2]),
				.tick_out(sel_tick[s])
			);
		end
	endgenerate

	assign RX_CLK_A_OUT = sel_tick[0];
	assign TX_CLK_A_OUT = sel_tick[1];
	assign RX_CLK_B_OUT = sel_tick[2];
	assign TX_CLK_B_OUT = sel_tick[3];

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	assign setup_rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
	assign acc = PSEL_IN && PENABLE_IN;
	assign wr = acc && PWRITE_IN;
	assign rd = acc && !PWRITE_IN;
	assign idx = reg_index(PADDR_IN);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = acc && (idx == 4'hf);
	assign PRDATA_OUT = rdata_q;
	assign start_cmd = rd && (idx == 4'h9);
	assign stop_cmd = rd && (idx == 4'ha);
	assign cmd = PWDATA_IN[`BCT_CMD_LO+3:`BCT_CMD_LO];
	assign to_on_a = wr && (idx == 4'h7) && (cmd == `BCT_CMD_TIMEOUT_ON);
	assign to_on_b = wr && (idx == 4'h8) && (cmd == `BCT_CMD_TIMEOUT_ON);

	// Read data is built in the setup cycle so it is a flop output
	// when the zero-wait access phase samples it.
	always @*
	begin
		rd_mux = 32'h0;
		if (idx == 4'h0)
			rd_mux = {29'h0, ext_a_q};
		else if (idx == 4'h1)
			rd_mux = {29'h0, ext_b_q};
		else if (idx == 4'h2)
			rd_mux = {25'h0, aux_q, 4'h0};
		else if (idx == 4'h3)
			rd_mux = {24'h0, pre_lo_q};
		else if (idx == 4'h4)
			rd_mux = {24'h0, pre_hi_q};
		else if (idx == 4'h5)
			rd_mux = {28'h0, ready_q, 3'h0};
		else if (idx == 4'h6)
			rd_mux = {28'h0, mask_q, 3'h0};
		else if (idx == 4'hb)
			rd_mux = {18'h0, sel_q[1], 2'h0, sel_q[0]};
		else if (idx == 4'hc)
			rd_mux = {18'h0, sel_q[3], 2'h0, sel_q[2]};
		else if (idx == 4'hd)
			rd_mux = {15'h0, ct_out_q, count_q};
	end

	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
			rdata_q <= 32'h0;
		else if (setup_rd)
			rdata_q <= rd_mux;
	end

	// Software registers; channel B extended bits are kept but unused.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ext_a_q <= 3'h0;
			ext_b_q <= 3'h0;
			aux_q <= `BCT_AUX_RST;
			pre_lo_q <= `BCT_PRELOAD_RST;
			pre_hi_q <= `BCT_PRELOAD_RST;
			mask_q <= 1'b0;
			sel_q[0] <= `BCT_SEL_RST;
			sel_q[1] <= `BCT_SEL_RST;
			sel_q[2] <= `BCT_SEL_RST;
			sel_q[3] <= `BCT_SEL_RST;
		end
		else if (wr)
		begin
			if (idx == 4'h0)
				ext_a_q <= PWDATA_IN[2:0];
			else if (idx == 4'h1)
				ext_b_q <= PWDATA_IN[2:0];
			else if (idx == 4'h2)
				aux_q <= PWDATA_IN[`BCT_AUX_MODE_BIT:`BCT_AUX_SRC_LO];
			else if (idx == 4'h3)
				pre_lo_q <= PWDATA_IN[7:0];
			else if (idx == 4'h4)
				pre_hi_q <= PWDATA_IN[7:0];
			else if (idx == 4'h6)
				mask_q <= PWDATA_IN[`BCT_READY_BIT];
			else if (idx == 4'hb)
			begin
				sel_q[0] <= PWDATA_IN[5:0];
				sel_q[1] <= PWDATA_IN[`BCT_SEL_TX_LO+5:`BCT_SEL_TX_LO];
			end
			else if (idx == 4'hc)
			begin
				sel_q[2] <= PWDATA_IN[5:0];
				sel_q[3] <= PWDATA_IN[`BCT_SEL_TX_LO+5:`BCT_SEL_TX_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// Time-out mode enables
	// ------------------------------------------------------------
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			to_a_q <= 1'b0;
			to_b_q <= 1'b0;
		end
		else if (wr && (idx == 4'h7))
		begin
			if (cmd == `BCT_CMD_TIMEOUT_ON)
				to_a_q <= 1'b1;
			else if (cmd == `BCT_CMD_TIMEOUT_OFF)
				to_a_q <= 1'b0;
		end
		else if (wr && (idx == 4'h8))
		begin
			if (cmd == `BCT_CMD_TIMEOUT_ON)
				to_b_q <= 1'b1;
			else if (cmd == `BCT_CMD_TIMEOUT_OFF)
				to_b_q <= 1'b0;
		end
	end

	assign to_any = to_a_q || to_b_q;
	assign to_enter = to_on_a || to_on_b;
	// Either enabled receiver restarts the shared counter.
	assign char_in = (RX_CHAR_A_IN && to_a_q) || (RX_CHAR_B_IN && to_b_q);

	// ------------------------------------------------------------
	// Counter/timer
	// ------------------------------------------------------------
	assign preload = {pre_hi_q, pre_lo_q};
	assign timer_mode = aux_q[2];

	// Clock source choice from the auxiliary field.
	always @*
	begin
		case (aux_q[1:0])
			`BCT_SRC_EXT_PIN: ct_tick = pin_rise[1];
			`BCT_SRC_REF: ct_tick = ref_tick;
			`BCT_SRC_REF_DIV16: ct_tick = ref16_tick;
			default: ct_tick = sel_tick[1];
		endcase
	end

	assign expire = to_any && running_q && ct_tick
		&& (count_q <= 16'h0001);

	// Start and stop are ignored in time-out mode, where received
	// characters alone restart the count.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			count_q <= 16'h0000;
			ct_out_q <= 1'b1;
			running_q <= 1'b0;
		end
		else if (to_any || to_enter)
		begin
			if (to_enter)
				running_q <= 1'b0;
			else if (char_in)
			begin
				count_q <= preload;
				running_q <= 1'b1;
			end
			else if (expire)
			begin
				count_q <= 16'h0000;
				running_q <= 1'b0;
			end
			else if (running_q && ct_tick)
				count_q <= count_q - 1'b1;
		end
		else if (timer_mode)
		begin
			// Stop has no effect here: the wave keeps running.
			if (start_cmd)
			begin
				count_q <= preload;
				ct_out_q <= 1'b1;
			end
			else if (ct_tick)
			begin
				if (count_q <= 16'h0001)
				begin
					count_q <= preload;
					ct_out_q <= ~ct_out_q;
				end
				else
					count_q <= count_q - 1'b1;
			end
		end
		else
		begin
			if (start_cmd)
			begin
				count_q <= preload;
				ct_out_q <= 1'b1;
				running_q <= 1'b1;
			end
			else if (stop_cmd)
				running_q <= 1'b0;
			else if (running_q && ct_tick)
			begin
				if (count_q == 16'h0000)
					count_q <= `BCT_ROLLOVER;
				else
					count_q <= count_q - 1'b1;
				if (count_q == 16'h0001)
					ct_out_q <= 1'b0;
			end
		end
	end

	// Falling output edge, a one-cycle strobe in the first cycle the output is low.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
			ct_prev_q <= 1'b1;
		else
			ct_prev_q <= ct_out_q;
	end

	assign ct_fall = ct_prev_q && !ct_out_q;
	assign CT_OUT_OUT = ct_out_q;

	// ------------------------------------------------------------
	// Ready flag and interrupt
	// ------------------------------------------------------------
	// A set in the same cycle as any clear wins, so no event is lost.
	always @(posedge CLK_IN or negedge rst_n_q)
	begin
		if (!rst_n_q)
			ready_q <= 1'b0;
		else if ((ct_fall && !to_any) || expire)
			ready_q <= 1'b1;
		else if (stop_cmd || to_enter || (to_any && char_in))
			ready_q <= 1'b0;
		else if (wr && (idx == 4'h5) && PWDATA_IN[`BCT_READY_BIT])
			ready_q <= 1'b0;
	end

	assign IRQ_OUT = ready_q && mask_q;

endmodule

/* File: test/bct_far_model.sv */
// ----------------------------------------------------------------
// Timing sources that sit outside the block
// ----------------------------------------------------------------
// Free-running reference oscillator and one external timing input.
// Both half periods are whole multiples of the 50 ns system clock
// and land on its falling edges, between rising edges, so every synchronised count is exact.
module bct_far_model #(
	parameter int REF_HALF_NS = 200,
	parameter int EXT_HALF_NS = 500
) (
	output logic ref_clk_out,
	output logic ext_clk_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// A real oscillator never stops, so neither does this one.
	initial
	begin
		ref_clk_out = 1'b0;
		forever #(REF_HALF_NS) ref_clk_out = ~ref_clk_out;
	end

	// The external timing input also runs freely between frames.
	initial
	begin
		ext_clk_out = 1'b0;
		forever #(EXT_HALF_NS) ext_clk_out = ~ext_clk_out;
	end
endmodule

/* File: test/bct_top_checker.sv */
`include "bct_defs.vh"

module bct_top_checker #(
	parameter AW = 12
) (
	input wire CLK_IN,
	input wire NRST_IN,
	input wire REF_CLOCK_IN,
	input wire EXT_CT_IN,
	input wire EXT_CLK_A_IN,
	input wire EXT_CLK_B_IN,
	input wire RX_CHAR_A_IN,
	input wire RX_CHAR_B_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [AW-1:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [31:0] PRDATA_OUT,
	input wire PREADY_OUT,
	input wire PSLVERR_OUT,
	input wire IRQ_OUT,
	input wire CT_OUT_OUT,
	input wire RX_CLK_A_OUT,
	input wire TX_CLK_A_OUT,
	input wire RX_CLK_B_OUT,
	input wire TX_CLK_B_OUT
);
	// ----------------------------------------------------------------
	// Bus decode and time-out tracking
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!NRST_IN);

	// Start, stop and command accesses as taken at the access edge.
	wire acc = PSEL_IN && PENABLE_IN;
	wire rd_start = acc && !PWRITE_IN && PADDR_IN == `BCT_OFF_START;
	wire rd_stop = acc && !PWRITE_IN && PADDR_IN == `BCT_OFF_STOP;
	wire wr_a = acc && PWRITE_IN && PADDR_IN == `BCT_OFF_CMD_A;
	wire wr_b = acc && PWRITE_IN && PADDR_IN == `BCT_OFF_CMD_B;
	wire [3:0] code = PWDATA_IN[7:4];
	reg [1:0] to_q;
	reg [1:0] to_d;

	// Start is ignored while time-out runs, so that state is tracked.
	always @*
	begin
		to_d = to_q;
		if (wr_a)
			to_d[0] = code == `BCT_CMD_TIMEOUT_ON ? 1'b1 :
				code == `BCT_CMD_TIMEOUT_OFF ? 1'b0 : to_q[0];
		if (wr_b)
			to_d[1] = code == `BCT_CMD_TIMEOUT_ON ? 1'b1 :
				code == `BCT_CMD_TIMEOUT_OFF ? 1'b0 : to_q[1];
	end

	always @(posedge CLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
			to_q <= 2'h0;
		else
			to_q <= to_d;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_ZERO_WAIT: assert property (acc |-> PREADY_OUT)
		else $error("access phase without ready");
	AST_STOP_CLEARS: assert property (rd_stop |=> !IRQ_OUT)
		else $error("stop left the ready interrupt up");
	AST_START_LOADS: assert property (rd_start && to_q == 2'h0 |=> CT_OUT_OUT)
		else $error("start did not raise the output");
	AST_UNMAPPED: assert property (acc && PADDR_IN > `BCT_OFF_COUNT |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
		else $error("unmapped access not refused");
	AST_ERR_IN_ACCESS: assert property (!PENABLE_IN |-> !PSLVERR_OUT)
		else $error("error outside access phase");
	AST_RXA_PULSE: assert property (RX_CLK_A_OUT |=> !RX_CLK_A_OUT)
		else $error("receive clock strobe too long");
	AST_TXB_PULSE: assert property ($rose(TX_CLK_B_OUT) |=> $fell(TX_CLK_B_OUT))
		else $error("transmit clock strobe too long");
	AST_COUNT_READ: assert property (acc && !PWRITE_IN && PADDR_IN == `BCT_OFF_COUNT |-> PRDATA_OUT[16] == $past(CT_OUT_OUT))
		else $error("count read disagrees with output");
	AST_TO_ENTRY: assert property ((wr_a || wr_b) && code == `BCT_CMD_TIMEOUT_ON |=> !IRQ_OUT [*4])
		else $error("time-out entry kept the flag");

	COV_CT_FALL: cover property ($fell(CT_OUT_OUT));
	COV_STOP_IRQ: cover property (rd_stop && IRQ_OUT);
	COV_TXB: cover property ($rose(TX_CLK_B_OUT));
endmodule

bind bct_top bct_top_checker #(.AW(AW)) u_chk (.CLK_IN(CLK_IN),
	.NRST_IN(NRST_IN), .REF_CLOCK_IN(REF_CLOCK_IN), .EXT_CT_IN(EXT_CT_IN),
	.EXT_CLK_A_IN(EXT_CLK_A_IN), .EXT_CLK_B_IN(EXT_CLK_B_IN),
	.RX_CHAR_A_IN(RX_CHAR_A_IN), .RX_CHAR_B_IN(RX_CHAR_B_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
	.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
	.CT_OUT_OUT(CT_OUT_OUT), .RX_CLK_A_OUT(RX_CLK_A_OUT),
	.TX_CLK_A_OUT(TX_CLK_A_OUT), .RX_CLK_B_OUT(RX_CLK_B_OUT),
	.TX_CLK_B_OUT(TX_CLK_B_OUT));

/* File: test/bct_top_tb.sv */
`include "bct_defs.vh"

module bct_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Bench signals
	// ----------------------------------------------------------------
	localparam int REF_CYC = 8;
	localparam int EXT_CYC = 20;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic rxa = 1'b0;
	logic rxb = 1'b0;
	logic [31:0] rdata;
	logic perr_s;
	logic [4:0] mon_q = 5'h0;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	int g;
	wire [31:0] prdata;
	wire pready, perr, irq, ct, rxca, txca, rxcb, txcb, refc, extc;
	wire [4:0] mon = {txcb, rxcb, txca, rxca, ~ct};

	bct_far_model #(.REF_HALF_NS(REF_CYC * 25), .EXT_HALF_NS(EXT_CYC * 25))
		u_far (.ref_clk_out(refc), .ext_clk_out(extc));

	bct_top DUT (.CLK_IN(clk), .NRST_IN(nrst), .REF_CLOCK_IN(refc),
		.EXT_CT_IN(extc), .EXT_CLK_A_IN(extc), .EXT_CLK_B_IN(extc),
		.RX_CHAR_A_IN(rxa), .RX_CHAR_B_IN(rxb), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr),
		.PWDATA_IN(pwd), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .IRQ_OUT(irq), .CT_OUT_OUT(ct),
		.RX_CLK_A_OUT(rxca), .TX_CLK_A_OUT(txca), .RX_CLK_B_OUT(rxcb),
		.TX_CLK_B_OUT(txcb));

	// ----------------------------------------------------------------
	// Clock, edge history and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		forever #25 clk = ~clk;
	end

	// The run needs under 1400 cycles; the ceiling leaves wide margin.
	always @(posedge clk)
	begin
		mon_q <= mon;
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask

	// Waits n edges and then lets that edge's updates settle.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One transfer; the request holds until ready is seen high.
	// Only the bench ceiling ends a wait for ready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			padr <= a;
			pwd <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1)
				@(posedge clk);
			rdata = prdata;
			perr_s = perr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdata);
	endtask

	// Cycles between two rising edges of one watched line, -1 if none.
	task automatic gap(input int i, output int c);
		int n;
		begin
			n = 0;
			c = -1;
			cyc(1);
			while (!(mon[i] && !mon_q[i]) && n < 300)
			begin
				cyc(1);
				n++;
			end
			if (n < 300)
			begin
				c = 0;
				do
				begin
					cyc(1);
					c++;
				end while (!(mon[i] && !mon_q[i]) && c < 300);
			end
		end
	endtask

	// One received character on channel B when b is set, else on A.
	task automatic pulse_char(input logic b);
		@(posedge clk);
		{rxb, rxa} <= {b, !b};
		@(posedge clk);
		{rxb, rxa} <= 2'b00;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_and_regs();
		rd(`BCT_OFF_AUX_CTRL, 32'h0, "aux reset");
		rd(`BCT_OFF_CLK_SEL_A, 32'h0, "sel reset");
		rd(`BCT_OFF_COUNT, 32'h10000, "count reset");
		chk("ct reset", 32'h1, {31'h0, ct});
		apb(1'b1, `BCT_OFF_AUX_CTRL, 32'hffffffff);
		rd(`BCT_OFF_AUX_CTRL, 32'h70, "aux field");
		apb(1'b1, `BCT_OFF_EXT_MODE_B, 32'hffffffff);
		rd(`BCT_OFF_EXT_MODE_B, 32'h7, "ext b");
		apb(1'b1, `BCT_OFF_PRELOAD_HI, 32'h1ff);
		rd(`BCT_OFF_PRELOAD_HI, 32'hff, "preload hi");
		rd(12'h038, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, {31'h0, perr_s});
	endtask

	// Counter mode on the reference: five ticks, then one falling edge.
	task automatic t_counter();
		apb(1'b1, `BCT_OFF_INT_MASK, 32'h8);
		apb(1'b1, `BCT_OFF_AUX_CTRL, 32'h10);
		apb(1'b1, `BCT_OFF_PRELOAD_LO, 32'h5);
		apb(1'b1, `BCT_OFF_PRELOAD_HI, 32'h0);
		apb(1'b0, `BCT_OFF_START, 32'h0);
		cyc(2 * REF_CYC);
		chk("count running", 32'h1, {31'h0, ct});
		cyc(8 * REF_CYC);
		chk("count done", 32'h0, {31'h0, ct});
		rd(`BCT_OFF_INT_STATUS, 32'h8, "ready flag");
		apb(1'b0, `BCT_OFF_STOP, 32'h0);
		cyc(1);
		chk("stop irq", 32'h0, {31'h0, irq});
	endtask

	// Time-out held until a character, set on expiry, cleared by one.
	task automatic t_timeout();
		apb(1'b1, `BCT_OFF_CMD_A, 32'ha0);
		cyc(12 * REF_CYC);
		chk("held", 32'h0, {31'h0, irq});
		pulse_char(1'b0);
		cyc(2 * REF_CYC);
		chk("restarted", 32'h0, {31'h0, irq});
		cyc(8 * REF_CYC);
		chk("expired", 32'h1, {31'h0, irq});
		pulse_char(1'b0);
		cyc(2);
		chk("char clears", 32'h0, {31'h0, irq});
		apb(1'b1, `BCT_OFF_CMD_A, 32'hc0);
		apb(1'b1, `BCT_OFF_CMD_B, 32'ha0);
		pulse_char(1'b1);
		cyc(10 * REF_CYC);
		chk("expired b", 32'h1, {31'h0, irq});
		apb(1'b1, `BCT_OFF_CMD_B, 32'hc0);
		apb(1'b0, `BCT_OFF_STOP, 32'h0);
	endtask

	// Timer wave, its use as a clock, and the wave running on after stop.
	task automatic t_timer();
		apb(1'b1, `BCT_OFF_AUX_CTRL, 32'h50);
		apb(1'b1, `BCT_OFF_PRELOAD_LO, 32'h4);
		apb(1'b1, `BCT_OFF_CLK_SEL_A, 32'h201f);
		apb(1'b0, `BCT_OFF_START, 32'h0);
		gap(0, g);
		chk("timer period", 2 * 4 * REF_CYC, g);
		gap(1, g);
		chk("rx a from ct", 2 * 4 * REF_CYC, g);
		gap(2, g);
		chk("tx a external", EXT_CYC, g);
		// Stop just after a falling edge, so no new set races the clear.
		gap(0, g);
		chk("timer reload", 2 * 4 * REF_CYC, g);
		apb(1'b0, `BCT_OFF_STOP, 32'h0);
		cyc(1);
		chk("stop clears", 32'h0, {31'h0, irq});
		cyc(9 * REF_CYC);
		chk("runs on", 32'h1, {31'h0, irq});
	endtask

	// Fixed taps: 38.4k is six reference ticks, 230.4k is one.
	task automatic t_rates();
		apb(1'b1, `BCT_OFF_EXT_MODE_A, 32'h1);
		apb(1'b1, `BCT_OFF_CLK_SEL_B, 32'h1e1b);
		gap(3, g);
		chk("38k4 tap", 6 * REF_CYC, g);
		gap(4, g);
		chk("230k4 tap", REF_CYC, g);
		apb(1'b1, `BCT_OFF_EXT_MODE_A, 32'h0);
		// Let a strobe already in the pipeline drain first.
		cyc(2);
		gap(4, g);
		chk("ext off", 32'hffffffff, g);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_and_regs();
		t_counter();
		t_timeout();
		t_timer();
		t_rates();
		wrap_up();
	end
endmodule
